// ===== rtl/indirect_move_and_misc_ops.sv
// executor for indirect store, no-operation, option load and software reset
`timescale 1ns/1ps
module indirect_move_and_misc_ops
  import misc_ops_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [2:0] status_i,
  output logic instr_done_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] wreg_o,
  output logic [15:0] memory_pointer_reg0_o,
  output logic [15:0] memory_pointer_reg1_o,
  output logic [7:0] option_reg_o,
  output logic [2:0] status_o,
  output logic reset_instr_flag_o,
  output logic soft_reset_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] wreg_q, wreg_d;
  logic [15:0] ptr_q [2];
  logic [15:0] ptr_d [2];
  logic [7:0] option_q, option_d;
  logic [2:0] status_q, status_d;
  // power-up value only: reset_i must not erase the record of a software reset
  logic ri_q = 1'b1;
  logic ri_d;
  logic rst_req_q, rst_req_d;
  logic done_q, done_d;
  logic we_q, we_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  exec_state_type state_q, state_d;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic is_nop, is_reset, is_option, is_loadw, is_store_mode, is_store_rel, is_store;
  logic sel;
  logic [15:0] calc_addr, calc_ptr;
  always_comb begin
    is_nop = instr_valid_i && (instr_i == OPC_NOP);
    is_reset = instr_valid_i && (instr_i == OPC_RESET);
    is_option = instr_valid_i && (instr_i == OPC_OPTION);
    is_loadw = instr_valid_i && ((instr_i & MASK_LOAD_W) == OPC_LOAD_W);
    is_store_mode = instr_valid_i && ((instr_i & MASK_STORE_MODE) == OPC_STORE_MODE);
    is_store_rel = instr_valid_i && ((instr_i & MASK_STORE_REL) == OPC_STORE_REL);
    is_store = is_store_mode || is_store_rel;
    sel = is_store_rel ? instr_i[SEL_REL_BIT] : instr_i[SEL_MODE_BIT];
  end

  pointer_calc u_calc (
    .ptr_i(sel ? ptr_q[1] : ptr_q[0]),
    .rel_i(is_store_rel),
    .mode_i(instr_i[MODE_LSB +: 2]),
    .offset_i(instr_i[OFFS_LSB +: OFFS_W]),
    .addr_o(calc_addr),
    .ptr_next_o(calc_ptr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    wreg_d = wreg_q;
    option_d = option_q;
    status_d = status_i;
    ri_d = ri_q;
    rst_req_d = 1'b0;
    done_d = 1'b0;
    we_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    state_d = state_q;
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    case (state_q)
      ST_RUN: begin
        if (instr_valid_i) begin
          done_d = 1'b1;
        end
        if (is_loadw) begin
          wreg_d = instr_i[LIT_LSB +: DATA_W];
        end
        if (is_store) begin
          // status follows its input only: pointer math never touches flags
          we_d = 1'b1;
          addr_d = calc_addr;
          wdata_d = wreg_q;
          ptr_d[sel] = calc_ptr;
        end
        if (is_option) begin
          option_d = wreg_q;
        end
        if (is_reset) begin
          ri_d = 1'b0;
          rst_req_d = 1'b1;
          state_d = ST_RESET_REQ;
        end
      end
      ST_RESET_REQ: begin
        // hold here until the device reset, driven by soft_reset_o, comes back
        rst_req_d = 1'b1;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wreg_q <= WREG_RESET;
      ptr_q[0] <= PTR_RESET;
      ptr_q[1] <= PTR_RESET;
      option_q <= OPTION_RESET;
      status_q <= 3'h0;
      rst_req_q <= 1'b0;
      done_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= PTR_RESET;
      wdata_q <= WREG_RESET;
      state_q <= ST_RUN;
    end else begin
      wreg_q <= wreg_d;
      ptr_q[0] <= ptr_d[0];
      ptr_q[1] <= ptr_d[1];
      option_q <= option_d;
      status_q <= status_d;
      rst_req_q <= rst_req_d;
      done_q <= done_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      state_q <= state_d;
    end
  end

  // the flag survives the reset it reports, so it is not cleared by reset_i
  always_ff @(posedge ref_clk_i) begin
    ri_q <= ri_d;
  end

  always_comb begin
    instr_done_o = done_q;
    mem_we_o = we_q;
    mem_addr_o = addr_q;
    mem_wdata_o = wdata_q;
    wreg_o = wreg_q;
    memory_pointer_reg0_o = ptr_q[0];
    memory_pointer_reg1_o = ptr_q[1];
    option_reg_o = option_q;
    status_o = status_q;
    reset_instr_flag_o = ri_q;
    soft_reset_o = rst_req_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  store_data_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store) |=> (mem_we_o && mem_wdata_o == $past(wreg_q)))
    else $error("indirect store wrote wrong data");
  rel_ptr_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store_rel && !instr_i[SEL_REL_BIT]) |=> $stable(ptr_q[0]))
    else $error("relative store moved the pointer");
  rel_addr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store_rel && !instr_i[SEL_REL_BIT]) |=>
    (mem_addr_o == $past(ptr_q[0]) + {{10{$past(instr_i[5])}}, $past(instr_i[5:0])}))
    else $error("relative store used wrong address");
  pre_inc_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store_mode && instr_i[2:0] == 3'h0) |=>
    (ptr_q[0] == $past(ptr_q[0]) + 16'h0001 && mem_addr_o == ptr_q[0]))
    else $error("pre-increment wrong");
  post_dec_wrap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store_mode && instr_i[2:0] == 3'h3 && ptr_q[0] == 16'h0000) |=>
    (ptr_q[0] == 16'hFFFF && mem_addr_o == 16'h0000))
    else $error("post-decrement did not wrap");
  flags_pass_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    is_store |=> status_o == $past(status_i))
    else $error("store changed status flags");
  option_load_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_option) |=> (option_reg_o == $past(wreg_q) && !mem_we_o))
    else $error("option load wrong");
  soft_reset_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_reset) |=> (soft_reset_o && !reset_instr_flag_o) [*2])
    else $error("software reset not raised");
  nop_quiet_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_nop) |=> (instr_done_o && !mem_we_o && $stable(wreg_q) && $stable(option_q)))
    else $error("nop changed state");
  // once a software reset is pending every later instruction must be refused
  refuse_after_reset_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RESET_REQ) |=> (soft_reset_o && !instr_done_o && !mem_we_o))
    else $error("instruction taken while reset pending");
  done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !instr_valid_i |=> !instr_done_o)
    else $error("done raised without an instruction");
  rel_ptr1_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store_rel && instr_i[SEL_REL_BIT]) |=> $stable(ptr_q[1]))
    else $error("relative store moved pointer one");
  other_ptr_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && is_store && !sel) |=> $stable(ptr_q[1]))
    else $error("store on pointer zero moved pointer one");
  option_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_q == ST_RUN && !is_option) |=> $stable(option_q))
    else $error("option register changed without option load");
  cover_store_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) state_q == ST_RUN && is_store_mode);
  cover_rel_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) state_q == ST_RUN && is_store_rel);
  cover_option_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) state_q == ST_RUN && is_option);
  cover_reset_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) soft_reset_o);
  cover_nop_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) state_q == ST_RUN && is_nop);
endmodule

// ===== rtl/misc_ops_pkg.sv
// package: opcodes, field layouts, reset values and widths for the misc/indirect-store executor
package misc_ops_pkg;
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] WREG_RESET = 8'h00;
  // opcode encodings (14-bit instruction word)
  localparam logic [13:0] OPC_NOP = 14'h0000;
  localparam logic [13:0] OPC_RESET = 14'h0001;
  localparam logic [13:0] OPC_OPTION = 14'h0062;
  localparam logic [13:0] OPC_LOAD_W = 14'h3000;
  localparam logic [13:0] MASK_LOAD_W = 14'h3F00;
  localparam logic [13:0] OPC_STORE_MODE = 14'h0018;
  localparam logic [13:0] MASK_STORE_MODE = 14'h3FF8;
  localparam logic [13:0] OPC_STORE_REL = 14'h3F80;
  localparam logic [13:0] MASK_STORE_REL = 14'h3F80;
  // field positions
  localparam int SEL_MODE_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int SEL_REL_BIT = 6;
  localparam int OFFS_LSB = 0;
  localparam int OFFS_W = 6;
  localparam int LIT_LSB = 0;
  typedef enum logic [1:0] {
    MODE_PRE_INC = 2'b00,
    MODE_PRE_DEC = 2'b01,
    MODE_POST_INC = 2'b10,
    MODE_POST_DEC = 2'b11
  } pointer_update_mode_type;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RESET_REQ = 2'b01
  } exec_state_type;
endpackage

// ===== rtl/pointer_calc.sv
// pointer arithmetic for the indirect store: effective address and updated pointer
`timescale 1ns/1ps
module pointer_calc
  import misc_ops_pkg::*;
(
  input wire logic [15:0] ptr_i,
  input wire logic rel_i,
  input wire logic [1:0] mode_i,
  input wire logic [5:0] offset_i,
  output logic [15:0] addr_o,
  output logic [15:0] ptr_next_o
);
  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] offs_ext;
  always_comb begin
    // natural 16-bit overflow gives wrap at both ends
    inc = ptr_i + 16'h0001;
    dec = ptr_i - 16'h0001;
    offs_ext = {{10{offset_i[5]}}, offset_i};
    if (rel_i) begin
      addr_o = ptr_i + offs_ext;
      ptr_next_o = ptr_i;
    end else begin
      case (pointer_update_mode_type'(mode_i))
        MODE_PRE_INC: begin
          addr_o = inc;
          ptr_next_o = inc;
        end
        MODE_PRE_DEC: begin
          addr_o = dec;
          ptr_next_o = dec;
        end
        MODE_POST_INC: begin
          addr_o = ptr_i;
          ptr_next_o = inc;
        end
        default: begin
          addr_o = ptr_i;
          ptr_next_o = dec;
        end
      endcase
    end
  end
endmodule

// ===== verif/data_mem_model.sv
// data memory partner: takes every write strobe of the executor
`timescale 1ns/1ps
module data_mem_model (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [15:0] last_addr_o,
  output logic [7:0] last_data_o,
  output int wr_cnt_o
);
  initial wr_cnt_o = 0;
  // no read port: the executor only stores, so the last write and the write count are all there is to see
  always @(posedge ref_clk_i) begin
    if (we_i) begin
      last_addr_o <= addr_i;
      last_data_o <= wdata_i;
      wr_cnt_o <= wr_cnt_o + 1;
    end
  end
endmodule

// ===== verif/test_indirect_move_and_misc_ops.sv
// self-checking bench for the indirect store and misc instruction executor
`timescale 1ns/1ps
module test_indirect_move_and_misc_ops;
  import misc_ops_pkg::*;
  logic ref_clk_i, reset_i, instr_valid_i, instr_done_o, mem_we_o, reset_instr_flag_o, soft_reset_o;
  logic [13:0] instr_i;
  logic [2:0] status_i, status_o;
  logic [15:0] mem_addr_o, memory_pointer_reg0_o, memory_pointer_reg1_o, last_addr;
  logic [7:0] mem_wdata_o, wreg_o, option_reg_o, last_data;
  int wr_cnt, error_cnt = 0, n_compared = 0;
  indirect_move_and_misc_ops dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .status_i(status_i), .instr_done_o(instr_done_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .wreg_o(wreg_o),
    .memory_pointer_reg0_o(memory_pointer_reg0_o), .memory_pointer_reg1_o(memory_pointer_reg1_o),
    .option_reg_o(option_reg_o), .status_o(status_o), .reset_instr_flag_o(reset_instr_flag_o),
    .soft_reset_o(soft_reset_o));
  data_mem_model mem (.ref_clk_i(ref_clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .last_addr_o(last_addr), .last_data_o(last_data), .wr_cnt_o(wr_cnt));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction, results looked at just after the answering edge
  task automatic exec(input logic [13:0] w);
    @(posedge ref_clk_i);
    instr_i <= w;
    instr_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  // mode order chosen so both pointers cross 0000/FFFF both ways
  task automatic store_modes();
    logic [1:0] ord[4] = '{2'b11, 2'b00, 2'b10, 2'b01};
    logic [15:0] p, np;
    for (int i = 0; i < 8; i++) begin
      exec(OPC_LOAD_W | 14'(8'h30 + i));
      p = i[2] ? memory_pointer_reg1_o : memory_pointer_reg0_o;
      exec(OPC_STORE_MODE | {11'h000, i[2], ord[i % 4]});
      np = ord[i % 4][0] ? p - 16'h0001 : p + 16'h0001;
      chk("we", 16'h0001, 16'(mem_we_o));
      chk("addr", ord[i % 4][1] ? p : np, mem_addr_o);
      chk("wdata", 16'(8'h30 + i), 16'(mem_wdata_o));
      chk("ptr", np, i[2] ? memory_pointer_reg1_o : memory_pointer_reg0_o);
      chk("status", 16'(status_i), 16'(status_o));
    end
    @(posedge ref_clk_i);
    #1;
    chk("writes", 16'd8, 16'(wr_cnt));
    chk("lastdata", 16'h0037, 16'(last_data));
    chk("lastaddr", 16'h0000, last_addr);
  endtask
  task automatic store_rel();
    logic [5:0] k;
    logic [15:0] p;
    for (int i = 0; i < 4; i++) begin
      k = i[0] ? 6'h1F : 6'h20;
      p = i[1] ? memory_pointer_reg1_o : memory_pointer_reg0_o;
      exec(OPC_STORE_REL | {7'h00, i[1], k});
      chk("reladdr", p + {{10{k[5]}}, k}, mem_addr_o);
      chk("relptr", p, i[1] ? memory_pointer_reg1_o : memory_pointer_reg0_o);
    end
  endtask
  task automatic option_nop();
    logic [15:0] p0, p1;
    chk("optrst", 16'h00FF, 16'(option_reg_o));
    @(posedge ref_clk_i);
    status_i <= 3'b010;
    exec(OPC_LOAD_W | 14'h004F);
    exec(OPC_OPTION);
    chk("option", 16'h004F, 16'(option_reg_o));
    chk("optstat", 16'h0002, 16'(status_o));
    p0 = memory_pointer_reg0_o;
    p1 = memory_pointer_reg1_o;
    exec(OPC_NOP);
    chk("nopdone", 16'h0001, 16'(instr_done_o));
    chk("nopwe", 16'h0000, 16'(mem_we_o));
    chk("nopw", 16'h004F, 16'(wreg_o));
    chk("nopopt", 16'h004F, 16'(option_reg_o));
    chk("nopp0", p0, memory_pointer_reg0_o);
    chk("nopp1", p1, memory_pointer_reg1_o);
    @(posedge ref_clk_i);
    #1;
    chk("donepulse", 16'h0000, 16'(instr_done_o));
  endtask
  task automatic soft_reset();
    exec(OPC_RESET);
    chk("sreset", 16'h0001, 16'(soft_reset_o));
    chk("riflag", 16'h0000, 16'(reset_instr_flag_o));
    exec(OPC_LOAD_W | 14'h0077);
    chk("ignored", 16'h004F, 16'(wreg_o));
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    chk("srelease", 16'h0000, 16'(soft_reset_o));
    chk("rikept", 16'h0000, 16'(reset_instr_flag_o));
    chk("optback", 16'h00FF, 16'(option_reg_o));
    chk("wregback", 16'h0000, 16'(wreg_o));
    exec(OPC_LOAD_W | 14'h0012);
    chk("resume", 16'h0012, 16'(wreg_o));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 60 cycles of work; 1000 cycles means a hang
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    reset_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = OPC_NOP;
    status_i = 3'b101;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    chk("riinit", 16'h0001, 16'(reset_instr_flag_o));
    store_modes();
    store_rel();
    option_nop();
    soft_reset();
    final_report();
  end
endmodule
